// ===== src/wda_cfg.svh
// Constants for the waveform display addressing block.
`ifndef WDA_CFG_SVH
`define WDA_CFG_SVH
`define WDA_REG_CTRL 8'h00
`define WDA_REG_MAG 8'h04
`define WDA_REG_STAT 8'h08
`define WDA_REG_START 8'h0C
`define WDA_CTRL_RUN 0
`define WDA_CTRL_XY 1
`define WDA_CTRL_ERT 2
`define WDA_CTRL_ROLL 3
`define WDA_CTRL_MAG 4
`define WDA_CTRL_VEXP 5
`define WDA_CTRL_VERTICAL_COMPRESS 6
`define WDA_CTRL_YW_LO 8
`define WDA_CTRL_XW_LO 12
`define WDA_CTRL_RST 32'h0000_0000
`define WDA_CTRL_MASK 32'h0000_777F
`define WDA_MAG_RST 10'h000
`define WDA_LAST_1024 10'h3FF
`define WDA_LAST_820 10'h333
`define WDA_LEFT_1024 10'h00C
`define WDA_LEFT_820 10'h00A
`define WDA_HORZ_MAX 16'sh03FF
`define WDA_MAG_FACTOR 16'sh000A
`define WDA_SCALE_100 2'h0
`define WDA_SCALE_80 2'h1
`define WDA_SCALE_XY 2'h2
`define WDA_FIFO_DEPTH 16
`endif

// ===== src/wda_pkg.sv
// Types shared by the waveform display addressing block.
package wda_pkg;
  typedef enum logic [2:0] {
    WDA_WAIT_Y,
    WDA_DATA_Y,
    WDA_WAIT_X,
    WDA_DATA_X,
    WDA_PUSH
  } wda_fetch_t;

  typedef struct packed {
    logic blank;
    logic [9:0] horz;
    logic [7:0] vert;
  } wda_point_t;
endpackage

// ===== src/wda_stream_if.sv
// Valid and ready stream carrier between the display block and its FIFO.
`timescale 1ns/1ns
`default_nettype none
interface wda_stream_if #(parameter int WIDTH = 19);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== src/wda_fifo.sv
// Point FIFO with registered read data and honest full and empty.
`timescale 1ns/1ns
`default_nettype none
module wda_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  wda_stream_if.snk s_in,
  wda_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [WIDTH-1:0] dout_r;
  logic dvalid_r;
  logic push;
  logic pop;

  // The output stage reloads only when it is empty or being taken, so a stalled drain fills the array.
  assign s_in.ready = (cnt_r != (AW+1)'(DEPTH));
  assign push = s_in.valid && s_in.ready;
  assign pop = (cnt_r != '0) && (!dvalid_r || s_out.ready);
  assign s_out.valid = dvalid_r;
  assign s_out.data = dout_r;

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wp_r] <= s_in.data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dout_r <= '0;
      dvalid_r <= 1'b0;
    end
    else if (pop)
    begin
      dout_r <= mem[rp_r];
      dvalid_r <= 1'b1;
    end
    else if (s_out.ready)
    begin
      dvalid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== src/wda_display_top.sv
// Waveform display addressing: memory fetch, horizontal placement and DAC code output.
// What this block does
// - Vertical code is the 8-bit sample read from waveform memory per point.
// - Time displays take the horizontal code from a 10-bit point counter.
// - X-versus-Y displays take the horizontal code from the X waveform sample.
// - Digital ten-times horizontal magnification, time displays only, memory untouched.
// - 1024-point records put point 12 at left line, 100 points per division.
// - 820-point records put point 10 at left line, 80 points per division.
// - X-versus-Y maps code 3 left, 253 at division ten, 25 per division.
// - Without expand or compress, vertical 128 is centre, 25 codes per division.
// - Extended real-time records hold 80 per division and use 820-point placement.
// - Memory reads for display happen only in time-base display slots.
// - Roll mode, ignored in extended real-time, moves start address on each stored sample, wrapping at 1023.
//
// The plain strobed port and the register offsets were left to the implementer.
`include "wda_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module wda_display_top #(
  parameter int FIFO_DEPTH = `WDA_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_disp_slot,
  input wire logic i_sample_stored,
  output logic o_mem_rd,
  output logic [9:0] o_mem_addr,
  output logic [2:0] o_mem_wave,
  input wire logic [7:0] i_mem_data,
  input wire logic i_dac_load,
  output logic [7:0] o_vert_code,
  output logic [9:0] o_horz_code,
  output logic [1:0] o_horz_scale,
  output logic o_blank,
  output logic o_point_strobe,
  output logic o_vertical_expand,
  output logic o_vertical_compress
);
  localparam int PW = $bits(wda_pkg::wda_point_t);

  logic [31:0] ctrl_r;
  logic [9:0] mag_off_r;
  logic [9:0] start_r;
  logic [9:0] pc_r;
  logic [7:0] vsamp_r;
  logic [7:0] xsamp_r;
  logic [2:0] slot_sync_r;
  logic [2:0] load_sync_r;
  logic slot_edge;
  logic load_edge;
  wda_pkg::wda_fetch_t state_r;
  wda_pkg::wda_point_t point;
  logic run;
  logic xy_mode;
  logic ert_mode;
  logic roll_mode;
  logic mag_on;
  logic [9:0] horz_base;
  logic signed [15:0] mag_val;

  wda_stream_if #(.WIDTH(PW)) in_s ();
  wda_stream_if #(.WIDTH(PW)) out_s ();

  // Last point index of the active record length.
  function automatic logic [9:0] rec_last(input logic ert);
    rec_last = ert ? `WDA_LAST_820 : `WDA_LAST_1024;
  endfunction

  assign run = ctrl_r[`WDA_CTRL_RUN];
  assign xy_mode = ctrl_r[`WDA_CTRL_XY];
  assign ert_mode = ctrl_r[`WDA_CTRL_ERT];
  assign roll_mode = ctrl_r[`WDA_CTRL_ROLL] && !ert_mode;
  assign mag_on = ctrl_r[`WDA_CTRL_MAG] && !xy_mode;

  // Slot and load come from off-block pins, so each is synchronised before any edge detection.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      slot_sync_r <= 3'h0;
      load_sync_r <= 3'h0;
    end
    else
    begin
      slot_sync_r <= {slot_sync_r[1:0], i_disp_slot};
      load_sync_r <= {load_sync_r[1:0], i_dac_load};
    end
  end

  assign slot_edge = slot_sync_r[1] && !slot_sync_r[2];
  assign load_edge = load_sync_r[1] && !load_sync_r[2];

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl_r <= `WDA_CTRL_RST;
      mag_off_r <= `WDA_MAG_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `WDA_REG_CTRL)
      begin
        ctrl_r <= i_reg_wdata & `WDA_CTRL_MASK;
      end
      else if (i_reg_addr == `WDA_REG_MAG)
      begin
        mag_off_r <= i_reg_wdata[9:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= 32'h0000_0000;
    end
    else if (i_reg_rd)
    begin
      if (i_reg_addr == `WDA_REG_CTRL)
      begin
        o_reg_rdata <= ctrl_r;
      end
      else if (i_reg_addr == `WDA_REG_MAG)
      begin
        o_reg_rdata <= {22'h00_0000, mag_off_r};
      end
      else if (i_reg_addr == `WDA_REG_STAT)
      begin
        o_reg_rdata <= {6'h00, rec_last(ert_mode), 6'h00, pc_r};
      end
      else if (i_reg_addr == `WDA_REG_START)
      begin
        o_reg_rdata <= {22'h00_0000, start_r};
      end
      else
      begin
        o_reg_rdata <= 32'h0000_0000;
      end
    end
    else
    begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // Roll start pointer; the 10-bit add wraps from 1023 to 0 by itself.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      start_r <= 10'h000;
    end
    else if (!roll_mode)
    begin
      start_r <= 10'h000;
    end
    else if (i_sample_stored)
    begin
      start_r <= start_r + 10'h001;
    end
  end

  // Fetch sequence: reads are issued only on a display slot edge.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_r <= wda_pkg::WDA_WAIT_Y;
      o_mem_rd <= 1'b0;
      o_mem_addr <= 10'h000;
      o_mem_wave <= 3'h0;
      vsamp_r <= 8'h00;
      xsamp_r <= 8'h00;
    end
    else
    begin
      o_mem_rd <= 1'b0;
      if (!run)
      begin
        state_r <= wda_pkg::WDA_WAIT_Y;
      end
      else
      begin
        case (state_r)
          wda_pkg::WDA_WAIT_Y:
          begin
            if (slot_edge)
            begin
              o_mem_rd <= 1'b1;
              o_mem_addr <= start_r + pc_r;
              o_mem_wave <= ctrl_r[`WDA_CTRL_YW_LO +: 3];
              state_r <= wda_pkg::WDA_DATA_Y;
            end
          end
          wda_pkg::WDA_DATA_Y:
          begin
            vsamp_r <= i_mem_data;
            state_r <= xy_mode ? wda_pkg::WDA_WAIT_X : wda_pkg::WDA_PUSH;
          end
          wda_pkg::WDA_WAIT_X:
          begin
            if (slot_edge)
            begin
              o_mem_rd <= 1'b1;
              o_mem_wave <= ctrl_r[`WDA_CTRL_XW_LO +: 3];
              state_r <= wda_pkg::WDA_DATA_X;
            end
          end
          wda_pkg::WDA_DATA_X:
          begin
            xsamp_r <= i_mem_data;
            state_r <= wda_pkg::WDA_PUSH;
          end
          wda_pkg::WDA_PUSH:
          begin
            if (in_s.ready)
            begin
              state_r <= wda_pkg::WDA_WAIT_Y;
            end
          end
          default:
          begin
            state_r <= wda_pkg::WDA_WAIT_Y;
          end
        endcase
      end
    end
  end

  // Point counter advances once a point has entered the FIFO.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pc_r <= 10'h000;
    end
    else if (!run)
    begin
      pc_r <= 10'h000;
    end
    else if (state_r == wda_pkg::WDA_PUSH && in_s.ready)
    begin
      if (pc_r >= rec_last(ert_mode))
      begin
        pc_r <= 10'h000;
      end
      else
      begin
        pc_r <= pc_r + 10'h001;
      end
    end
  end

  // The 820-point record is shifted so point 10 lands on the same code as point 12 does.
  always_comb
  begin
    if (xy_mode)
    begin
      horz_base = {2'b00, xsamp_r};
    end
    else if (ert_mode)
    begin
      horz_base = pc_r + (`WDA_LEFT_1024 - `WDA_LEFT_820);
    end
    else
    begin
      horz_base = pc_r;
    end
  end

  // Magnification works on the code only, so stored records are never rewritten.
  always_comb
  begin
    mag_val = (signed'({6'h00, horz_base}) - signed'({6'h00, mag_off_r})) * `WDA_MAG_FACTOR
      + signed'({6'h00, mag_off_r});
    point.vert = vsamp_r;
    if (mag_on)
    begin
      point.blank = (mag_val < 16'sh0000) || (mag_val > `WDA_HORZ_MAX);
      point.horz = mag_val[9:0];
    end
    else
    begin
      point.blank = 1'b0;
      point.horz = horz_base;
    end
  end

  assign in_s.valid = run && (state_r == wda_pkg::WDA_PUSH);
  assign in_s.data = point;
  assign out_s.ready = load_edge;

  wda_fifo #(.WIDTH(PW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .s_in(in_s),
    .s_out(out_s)
  );

  // DAC codes change only on a load edge; a dry FIFO leaves them and raises no strobe.
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_vert_code <= 8'h00;
      o_horz_code <= 10'h000;
      o_blank <= 1'b1;
      o_point_strobe <= 1'b0;
    end
    else
    begin
      o_point_strobe <= load_edge && out_s.valid;
      if (load_edge && out_s.valid)
      begin
        o_vert_code <= out_s.data[7:0];
        o_horz_code <= out_s.data[17:8];
        o_blank <= out_s.data[18];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_horz_scale <= `WDA_SCALE_100;
      o_vertical_expand <= 1'b0;
      o_vertical_compress <= 1'b0;
    end
    else
    begin
      o_vertical_expand <= ctrl_r[`WDA_CTRL_VEXP];
      o_vertical_compress <= ctrl_r[`WDA_CTRL_VERTICAL_COMPRESS];
      if (xy_mode)
      begin
        o_horz_scale <= `WDA_SCALE_XY;
      end
      else if (ert_mode)
      begin
        o_horz_scale <= `WDA_SCALE_80;
      end
      else
      begin
        o_horz_scale <= `WDA_SCALE_100;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/wda_display_sva.sv
// Concurrent checks on the ports of the display addressing top.
`timescale 1ns/1ns
`default_nettype none
module wda_display_sva (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic i_disp_slot,
  input wire logic i_dac_load,
  input wire logic o_mem_rd,
  input wire logic [9:0] o_mem_addr,
  input wire logic [7:0] o_vert_code,
  input wire logic [9:0] o_horz_code,
  input wire logic [1:0] o_horz_scale,
  input wire logic o_point_strobe,
  input wire logic o_vertical_expand,
  input wire logic o_vertical_compress
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_ctrl_wr;
    i_reg_wr && (i_reg_addr == 8'h00);
  endsequence
  // A pin edge is seen after two sync stages and one edge detect, so the read follows it three edges later.
  sequence s_slot_seen;
    $past(i_disp_slot, 3) && !$past(i_disp_slot, 4);
  endsequence
  // The copy sits one register behind the control register, so it shows exactly two edges after the write.
  property p_vert_copy;
    s_ctrl_wr |-> ##2 ({o_vertical_compress, o_vertical_expand} == $past(i_reg_wdata[6:5], 2));
  endproperty
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  a_read_in_slot: assert property (o_mem_rd |-> s_slot_seen)
    else $error("memory read outside a slot");
  a_read_single: assert property (o_mem_rd |=> !o_mem_rd)
    else $error("memory read longer than one cycle");
  a_addr_hold: assert property (!o_mem_rd |-> $stable(o_mem_addr))
    else $error("address moved without a read");
  a_point_on_load: assert property (o_point_strobe |-> $past(i_dac_load, 3) && !$past(i_dac_load, 4))
    else $error("point strobe without load request");
  a_strobe_single: assert property (o_point_strobe |=> !o_point_strobe)
    else $error("point strobe longer than one cycle");
  a_codes_hold: assert property (!o_point_strobe |-> $stable(o_vert_code) && $stable(o_horz_code))
    else $error("codes changed without a point");
  a_xy_eight_bit: assert property (o_point_strobe && o_horz_scale == 2'h2 |-> o_horz_code[9:8] == 2'h0)
    else $error("wide horizontal code in xy display");
  a_vert_copy: assert property (p_vert_copy)
    else $error("expand or compress output wrong");
endmodule
bind wda_display_top wda_display_sva u_wda_display_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_disp_slot(i_disp_slot), .i_dac_load(i_dac_load), .o_mem_rd(o_mem_rd),
  .o_mem_addr(o_mem_addr), .o_vert_code(o_vert_code), .o_horz_code(o_horz_code),
  .o_horz_scale(o_horz_scale), .o_point_strobe(o_point_strobe),
  .o_vertical_expand(o_vertical_expand), .o_vertical_compress(o_vertical_compress));
`default_nettype wire

// ===== verif/wda_mem_model.sv
// Waveform memory model answering the display reads.
`timescale 1ns/1ns
`default_nettype none
module wda_mem_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_mem_rd,
  input wire logic [9:0] i_mem_addr,
  input wire logic [2:0] i_mem_wave,
  output logic [7:0] o_mem_data
);
  logic rd_d_r;
  logic [7:0] word;
  // The word depends on the low 8 address bits and the waveform, so a wrong index of either shows up.
  assign word = i_mem_addr[7:0] ^ {i_mem_wave, 5'h00};
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rd_d_r <= 1'b0;
    else
      rd_d_r <= i_mem_rd;
  end
  // Outside the read window the word is inverted, so an early or late sample cannot match by luck.
  assign o_mem_data = (i_mem_rd || rd_d_r) ? word : ~word;
endmodule
`default_nettype wire

// ===== verif/tb_wda_display_top.sv
// Self-checking bench for the display addressing top.
`timescale 1ns/1ns
`default_nettype none
module tb_wda_display_top;
  logic i_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_disp_slot, i_sample_stored, i_dac_load, o_mem_rd, o_blank;
  logic o_point_strobe, o_vertical_expand, o_vertical_compress, ok;
  logic [7:0] i_reg_addr, i_mem_data, o_vert_code;
  logic [31:0] i_reg_wdata, o_reg_rdata, d;
  logic [9:0] o_mem_addr, o_horz_code;
  logic [2:0] o_mem_wave;
  logic [1:0] o_horz_scale;
  int bad_count, n_checks, cnt;
  typedef struct {logic [31:0] ctrl; logic [9:0] mag; int pc; logic [1:0] sc; logic [9:0] h; logic bl;} wda_row_t;
  wda_row_t rows [7] = '{'{32'h0201, 10'h000, 3, 2'h0, 10'h003, 1'b0}, '{32'h0205, 10'h000, 3, 2'h1, 10'h005, 1'b0},
    '{32'h3203, 10'h000, 1, 2'h2, 10'h061, 1'b0}, '{32'h3213, 10'h000, 1, 2'h2, 10'h061, 1'b0},
    '{32'h0211, 10'h000, 2, 2'h0, 10'h014, 1'b0}, '{32'h0211, 10'h005, 6, 2'h0, 10'h00F, 1'b0},
    '{32'h0211, 10'h200, 0, 2'h0, 10'h000, 1'b1}};
  wda_display_top u_wda_display_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_disp_slot(i_disp_slot), .i_sample_stored(i_sample_stored), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .o_mem_wave(o_mem_wave), .i_mem_data(i_mem_data), .i_dac_load(i_dac_load), .o_vert_code(o_vert_code),
    .o_horz_code(o_horz_code), .o_horz_scale(o_horz_scale), .o_blank(o_blank), .o_point_strobe(o_point_strobe),
    .o_vertical_expand(o_vertical_expand), .o_vertical_compress(o_vertical_compress));
  wda_mem_model u_wda_mem_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mem_rd(o_mem_rd),
    .i_mem_addr(o_mem_addr), .i_mem_wave(o_mem_wave), .o_mem_data(i_mem_data));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  // Pins are synchronised inside, so each request is held well past the two-stage delay.
  task pin(input logic sel);
    ok = 1'b0;
    @(posedge i_clk);
    if (sel)
      i_dac_load <= 1'b1;
    else
      i_disp_slot <= 1'b1;
    repeat (6)
    begin
      @(posedge i_clk);
      #1 if ((sel ? o_point_strobe : o_mem_rd) === 1'b1) ok = 1'b1;
    end
    @(posedge i_clk);
    i_dac_load <= 1'b0;
    i_disp_slot <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    {i_reg_wr, i_reg_rd, i_disp_slot, i_sample_stored, i_dac_load} = 5'h00;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h0000_0000;
    i_sys_rst = 1'b1;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'(rows[i].mag));
      wr(8'h00, rows[i].ctrl);
      for (int p = 0; p <= rows[i].pc; p++)
      begin
        pin(1'b0);
        chk(32'(ok), 32'h1);
        if (rows[i].ctrl[1])
        begin
          pin(1'b0);
          chk(32'(ok), 32'h1);
        end
        pin(1'b1);
        chk(32'(ok), 32'h1);
        chk(32'(o_vert_code), 32'(p[7:0] ^ 8'h40));
      end
      chk(32'(o_horz_scale), 32'(rows[i].sc));
      if (!rows[i].bl) chk(32'(o_horz_code), 32'(rows[i].h));
      chk(32'(o_blank), 32'(rows[i].bl));
      rd(8'h08);
      chk(32'(d[9:0]), 32'(rows[i].pc + 1));
    end
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00);
    chk(d, 32'h0000_777F);
    chk(32'({o_vertical_expand, o_vertical_compress}), 32'h3);
    rd(8'h08);
    chk(d, 32'h0333_0000);
    wr(8'h08, 32'hFFFF_FFFF);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04);
    chk(d, 32'h0000_03FF);
    rd(8'h08);
    chk(d, 32'h0333_0000);
    rd(8'h10);
    chk(d, 32'h0000_0000);
    wr(8'h00, 32'h0000_0009);
    repeat (3)
    begin
      @(posedge i_clk);
      i_sample_stored <= 1'b1;
      @(posedge i_clk);
      i_sample_stored <= 1'b0;
    end
    rd(8'h0C);
    chk(d, 32'h0000_0003);
    pin(1'b0);
    chk(32'(ok), 32'h1);
    pin(1'b1);
    chk(32'(ok), 32'h1);
    chk(32'(o_mem_addr), 32'h3);
    chk(32'(o_vert_code), 32'h3);
    wr(8'h00, 32'h0000_0001);
    rd(8'h0C);
    chk(d, 32'h0000_0000);
    // Fill with no loads until slots are refused, then drain: FIFO, output stage and the stalled fetch hold 18.
    wr(8'h00, 32'h0000_0000);
    wr(8'h00, 32'h0000_0201);
    cnt = 0;
    repeat (20)
    begin
      pin(1'b0);
      cnt += int'(ok);
    end
    chk(32'(cnt), 32'd18);
    cnt = 0;
    repeat (20)
    begin
      pin(1'b1);
      cnt += int'(ok);
    end
    chk(32'(cnt), 32'd18);
    wr(8'h00, 32'h0000_0060);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(32'({o_blank, o_horz_scale, o_vertical_expand}), 32'h8);
    i_sys_rst <= 1'b0;
    rd(8'h00);
    chk(d, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
